// ---- hw/nrc_classifier.sv ----
// Nickel resistance-thermometer measured-value coder and range classifier.
// Assumes the front end delivers a linearized temperature in hundredths of a
// degree Celsius with a one-cycle strobe, plus a wire-break level; all inputs
// synchronous to clk. Registers over AXI4-Lite, one interrupt output.
// Notes on behaviour
// (R1) Standard sensor Celsius: tenths of a degree, nominal -600 to 2500.
// (R2) Standard Celsius above nominal up to 2950 keeps scaled code, class overrange.
// (R3) Standard reading above the overrange limit gives code 7FFF, any scale.
// (R4) Standard Celsius below -600 down to -1050 keeps scaled code, class underrange.
// (R5) Reading below the underrange limit gives code 8000.
// (R6) Standard Fahrenheit: tenths, nominal -760..4820, limits -1570..5630.
// (R7) Standard Kelvin: tenths, nominal 2132..5232, limits 1682..5682, else saturate.
// (R8) Climate Celsius: hundredths, nominal -6000..13000, limits -10500..15500.
// (R9) Climate Fahrenheit: hundredths, nominal -7600..26600, limits -15700..31100.
// (R10) Wire-break diagnostics on: broken wire gives 7FFF and a wire-break alarm.
// (R11) Wire-break check takes precedence over overflow and underflow checking.
// (R12) Wire-break off, limits on: broken wire gives 8000 and a low-limit alarm.
// (R13) Both checks off: broken wire gives 8000 only, no alarm.
// (R14) Each enabled diagnostic event makes a record and sets a status bit; irq rises only if that bit is unmasked.
// (R15) Output is a 16-bit two's-complement code per result, held until next.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
module nrc_classifier #(
    parameter int TEMP_WIDTH = 24
) (
    input wire logic clk,
    input wire logic reset_n,
    // Front end
    input wire logic sampleValid,
    input wire logic signed [TEMP_WIDTH-1:0] sampleTemp,
    input wire logic sampleWireBreak,
    // Result
    output logic signed [15:0] measValue,
    output nrc_pkg::nrc_class_type rangeClass,
    output logic resultValid,
    output logic diagAlarm,
    output logic irq,
    // AXI4-Lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ========================================================================
    // Helpers
    // ========================================================================
    // Pick limit set for sensor type and scale
    function automatic int limitOf(input nrc_pkg::nrc_ctrl_type c, input int idx);
        int lim;
        lim = nrc_pkg::STD_C_LIMITS[idx];
        if (c.climate)
        begin
            if (c.scale == nrc_pkg::SCALE_FAHRENHEIT)
                lim = nrc_pkg::CLIM_F_LIMITS[idx];
            else
                lim = nrc_pkg::CLIM_C_LIMITS[idx];
        end
        else if (c.scale == nrc_pkg::SCALE_FAHRENHEIT)
            lim = nrc_pkg::STD_F_LIMITS[idx];
        else if (c.scale == nrc_pkg::SCALE_KELVIN)
            lim = nrc_pkg::STD_K_LIMITS[idx];
        return lim;
    endfunction : limitOf

    // ========================================================================
    // Registers
    // ========================================================================
    nrc_pkg::nrc_ctrl_type ctrl;
    logic [3:0] status;
    logic [3:0] mask;
    logic [15:0] diagCount;
    nrc_pkg::nrc_class_type diagCause;

    // ========================================================================
    // Scaling and classification
    // ========================================================================
    int tempC;
    int scaled;
    nrc_pkg::nrc_result_type next_result;
    logic evWire;
    logic evLow;
    logic evHigh;

    // Scale input (hundredths of degC) to selected unit; a climate sensor with Kelvin selected stays in Celsius
    always_comb
    begin
        tempC = int'(sampleTemp);
        if (ctrl.climate)
        begin
            if (ctrl.scale == nrc_pkg::SCALE_FAHRENHEIT)
                scaled = (tempC * 9) / 5 + nrc_pkg::FAHR_OFFSET_HUNDREDTHS; // R9
            else
                scaled = tempC; // R8
        end
        else
        begin
            unique case (ctrl.scale)
                nrc_pkg::SCALE_FAHRENHEIT:
                    scaled = (tempC * 9) / 50 + nrc_pkg::FAHR_OFFSET_TENTHS; // R6
                nrc_pkg::SCALE_KELVIN:
                    scaled = tempC / 10 + nrc_pkg::KELVIN_OFFSET_TENTHS; // R7
                default:
                    scaled = tempC / 10; // R1
            endcase
        end
    end

    // Classify, saturate, and apply wire-break priority
    always_comb
    begin
        evWire = 1'b0;
        evLow = 1'b0;
        evHigh = 1'b0;
        next_result.code = 16'(scaled);
        next_result.rangeClass = nrc_pkg::CLASS_NOMINAL; // R1
        if (sampleWireBreak && ctrl.wireEn)
        begin
            next_result.code = nrc_pkg::CODE_OVERFLOW; // R10
            next_result.rangeClass = nrc_pkg::CLASS_WIREBREAK; // R11
            evWire = 1'b1; // R10
        end
        else if (sampleWireBreak)
        begin
            next_result.code = nrc_pkg::CODE_UNDERFLOW; // R12 R13
            next_result.rangeClass = nrc_pkg::CLASS_UNDERFLOW;
            evLow = ctrl.limitEn; // R12 R13
        end
        else if (scaled > limitOf(ctrl, 1))
        begin
            next_result.code = nrc_pkg::CODE_OVERFLOW; // R3
            next_result.rangeClass = nrc_pkg::CLASS_OVERFLOW;
            evHigh = ctrl.limitEn;
        end
        else if (scaled > limitOf(ctrl, 0))
            next_result.rangeClass = nrc_pkg::CLASS_OVERRANGE; // R2
        else if (scaled < limitOf(ctrl, 3))
        begin
            next_result.code = nrc_pkg::CODE_UNDERFLOW; // R5
            next_result.rangeClass = nrc_pkg::CLASS_UNDERFLOW;
            evLow = ctrl.limitEn;
        end
        else if (scaled < limitOf(ctrl, 2))
            next_result.rangeClass = nrc_pkg::CLASS_UNDERRANGE; // R4
    end

    // Result registers, held until next sample
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            measValue <= 16'sh0000;
            rangeClass <= nrc_pkg::CLASS_NOMINAL;
        end
        else if (sampleValid)
        begin
            measValue <= next_result.code; // R15
            rangeClass <= next_result.rangeClass; // R15
        end
    end

    // One-cycle result and alarm strobes
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            resultValid <= 1'b0;
            diagAlarm <= 1'b0;
        end
        else
        begin
            resultValid <= sampleValid;
            diagAlarm <= sampleValid && (evWire || evLow || evHigh);
        end
    end

    // Diagnostics record: event count and last cause
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            diagCount <= 16'h0000;
            diagCause <= nrc_pkg::CLASS_NOMINAL;
        end
        else if (sampleValid && (evWire || evLow || evHigh))
        begin
            diagCount <= diagCount + 16'h0001; // R14
            diagCause <= next_result.rangeClass; // R14
        end
    end

    // ========================================================================
    // AXI4-Lite write channel
    // ========================================================================
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite;
    logic [3:0] statusClear;

    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign statusClear = (doWrite && awAddr == nrc_pkg::ADDR_STATUS && wStrb[0])
        ? wData[3:0] : 4'h0;

    // Capture address and data in either order
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
        end
        else
        begin
            s_axi_awready <= !awHeld && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !wHeld && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= nrc_pkg::RESP_OKAY;
        end
        else if (doWrite)
        begin
            s_axi_bvalid <= 1'b1;
            unique case (awAddr)
                nrc_pkg::ADDR_CTRL, nrc_pkg::ADDR_STATUS, nrc_pkg::ADDR_MASK,
                nrc_pkg::ADDR_VALUE, nrc_pkg::ADDR_DIAG:
                    s_axi_bresp <= nrc_pkg::RESP_OKAY;
                default:
                    s_axi_bresp <= nrc_pkg::RESP_SLVERR;
            endcase
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Control and mask registers
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ctrl <= nrc_pkg::CTRL_RESET;
            mask <= nrc_pkg::MASK_RESET;
        end
        else if (doWrite && wStrb[0])
        begin
            if (awAddr == nrc_pkg::ADDR_CTRL)
                ctrl <= wData[4:0];
            if (awAddr == nrc_pkg::ADDR_MASK)
                mask <= wData[3:0];
        end
    end

    // ========================================================================
    // Interrupt status
    // ========================================================================
    logic [3:0] statusSet;

    always_comb
    begin
        statusSet = 4'h0;
        statusSet[nrc_pkg::STAT_WIRE_BIT] = sampleValid && evWire; // R14
        statusSet[nrc_pkg::STAT_LOW_BIT] = sampleValid && evLow; // R12
        statusSet[nrc_pkg::STAT_HIGH_BIT] = sampleValid && evHigh;
        statusSet[nrc_pkg::STAT_RESULT_BIT] = sampleValid;
    end

    // Sticky bits, set wins over write-one clear
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            status <= nrc_pkg::STAT_RESET;
        else
            status <= (status & ~statusClear) | statusSet;
    end

    // Level interrupt from unmasked status
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            irq <= 1'b0;
        else
            irq <= |(((status & ~statusClear) | statusSet) & mask); // R14
    end

    // ========================================================================
    // AXI4-Lite read channel
    // ========================================================================
    logic [31:0] readWord;
    logic readOk;

    // Read decode
    always_comb
    begin
        readWord = 32'h0000_0000;
        readOk = 1'b1;
        unique case (s_axi_araddr)
            nrc_pkg::ADDR_CTRL: readWord[4:0] = ctrl;
            nrc_pkg::ADDR_VALUE: readWord[18:0] = {rangeClass, measValue};
            nrc_pkg::ADDR_STATUS: readWord[3:0] = status;
            nrc_pkg::ADDR_MASK: readWord[3:0] = mask;
            nrc_pkg::ADDR_DIAG: readWord[18:0] = {diagCause, diagCount};
            default: readOk = 1'b0;
        endcase
    end

    // Address accept and data return
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= nrc_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= readWord;
                s_axi_rresp <= readOk ? nrc_pkg::RESP_OKAY : nrc_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule : nrc_classifier

// ---- hw/nrc_pkg.sv ----
// Package for the nickel resistance-thermometer code classifier.
// Assumes one 20 MHz clock, synchronous active-low reset, AXI4-Lite registers.
package nrc_pkg;

    // ========================================================================
    // Register map (byte addresses)
    // ========================================================================
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VALUE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    localparam logic [7:0] ADDR_DIAG = 8'h10;

    // Control fields
    localparam int CTRL_CLIMATE_BIT = 0;
    localparam int CTRL_SCALE_LSB = 1;
    localparam int CTRL_WIRE_EN_BIT = 3;
    localparam int CTRL_LIMIT_EN_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // Status and mask fields
    localparam int STAT_WIRE_BIT = 0;
    localparam int STAT_LOW_BIT = 1;
    localparam int STAT_HIGH_BIT = 2;
    localparam int STAT_RESULT_BIT = 3;
    localparam logic [3:0] STAT_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Saturated codes
    localparam logic signed [15:0] CODE_OVERFLOW = 16'sh7FFF;
    localparam logic signed [15:0] CODE_UNDERFLOW = 16'sh8000;

    // Scaling offsets (input is hundredths of a degree Celsius)
    localparam int KELVIN_OFFSET_TENTHS = 2732;
    localparam int FAHR_OFFSET_TENTHS = 320;
    localparam int FAHR_OFFSET_HUNDREDTHS = 3200;

    // Range limits per sensor and scale: nominal top, overrange top,
    // nominal bottom, underrange bottom
    localparam int STD_C_LIMITS [4] = '{2500, 2950, -600, -1050};
    localparam int STD_F_LIMITS [4] = '{4820, 5630, -760, -1570};
    localparam int STD_K_LIMITS [4] = '{5232, 5682, 2132, 1682};
    localparam int CLIM_C_LIMITS [4] = '{13000, 15500, -6000, -10500};
    localparam int CLIM_F_LIMITS [4] = '{26600, 31100, -7600, -15700};

    typedef enum logic [1:0] {
        SCALE_CELSIUS = 2'b00,
        SCALE_FAHRENHEIT = 2'b01,
        SCALE_KELVIN = 2'b10
    } nrc_scale_type;

    typedef enum logic [2:0] {
        CLASS_NOMINAL = 3'b000,
        CLASS_OVERRANGE = 3'b001,
        CLASS_UNDERRANGE = 3'b010,
        CLASS_OVERFLOW = 3'b011,
        CLASS_UNDERFLOW = 3'b100,
        CLASS_WIREBREAK = 3'b101
    } nrc_class_type;

    typedef struct packed {
        logic limitEn;
        logic wireEn;
        logic [1:0] scale;
        logic climate;
    } nrc_ctrl_type;

    typedef struct packed {
        logic signed [15:0] code;
        nrc_class_type rangeClass;
    } nrc_result_type;

endpackage : nrc_pkg

// ---- verification/nrc_classifier_sva.sv ----
// Checker for result timing and saturated codes.
// Assumes binding into nrc_classifier; one clock.
module nrc_classifier_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sampleValid,
    input wire logic sampleWireBreak,
    input wire logic signed [15:0] measValue,
    input wire nrc_pkg::nrc_class_type rangeClass,
    input wire logic resultValid,
    input wire logic diagAlarm
);
    // ========================================================================
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Broken wire sampled, result shown
    sequence s_brk;
        sampleValid && sampleWireBreak ##1 resultValid;
    endsequence

    property p_strobe;
        sampleValid |=> resultValid;
    endproperty
    property p_quiet;
        !sampleValid |=> !resultValid && !diagAlarm;
    endproperty
    property p_hold;
        !sampleValid |=> $stable(measValue) && $stable(rangeClass);
    endproperty
    property p_ovf;
        rangeClass == nrc_pkg::CLASS_OVERFLOW |-> measValue == 16'sh7FFF;
    endproperty
    property p_udf;
        rangeClass == nrc_pkg::CLASS_UNDERFLOW |-> measValue == 16'sh8000;
    endproperty
    property p_wire;
        rangeClass == nrc_pkg::CLASS_WIREBREAK |-> measValue == 16'sh7FFF;
    endproperty
    property p_prio;
        s_brk |-> rangeClass inside {nrc_pkg::CLASS_WIREBREAK, nrc_pkg::CLASS_UNDERFLOW};
    endproperty
    property p_alarm;
        diagAlarm |-> resultValid && rangeClass inside {nrc_pkg::CLASS_OVERFLOW,
            nrc_pkg::CLASS_UNDERFLOW, nrc_pkg::CLASS_WIREBREAK};
    endproperty

    a_strobe: assert property (p_strobe) else $error("no result after sample");
    a_quiet: assert property (p_quiet) else $error("result without sample");
    a_hold: assert property (p_hold) else $error("code not held");
    a_ovf: assert property (p_ovf) else $error("overflow code wrong");
    a_udf: assert property (p_udf) else $error("underflow code wrong");
    a_wire: assert property (p_wire) else $error("wire break code wrong");
    a_prio: assert property (p_prio) else $error("broken wire class wrong");
    a_alarm: assert property (p_alarm) else $error("alarm without event");
endmodule : nrc_classifier_sva

bind nrc_classifier nrc_classifier_sva i_nrc_classifier_sva (
    .clk(clk),
    .reset_n(reset_n),
    .sampleValid(sampleValid),
    .sampleWireBreak(sampleWireBreak),
    .measValue(measValue),
    .rangeClass(rangeClass),
    .resultValid(resultValid),
    .diagAlarm(diagAlarm)
);

// ---- verification/nrc_front_end.sv ----
// Front-end model: one-cycle conversion strobe with temperature.
// Assumes bench requests on go; one clock.
module nrc_front_end (
    input wire logic clk,
    input wire logic go,
    input wire logic signed [23:0] reqTemp,
    input wire logic reqBreak,
    output logic sampleValid,
    output logic signed [23:0] sampleTemp,
    output logic sampleWireBreak
);
    // ========================================================================
    // Strobe
    // Quiet at time zero
    initial
    begin
        sampleValid = 1'b0;
        sampleTemp = '0;
        sampleWireBreak = 1'b0;
    end

    // One strobe per request; idle data inverted so stale values mislead
    always @(posedge clk)
    begin
        sampleValid <= go;
        if (go)
        begin
            sampleTemp <= reqTemp;
            sampleWireBreak <= reqBreak;
        end
        else
        begin
            sampleTemp <= ~sampleTemp;
            sampleWireBreak <= ~sampleWireBreak;
        end
    end
endmodule : nrc_front_end

// ---- verification/testbench.sv ----
// Bench for the classifier: scaling, classes, wire break, interrupt.
// Assumes front-end model and checker compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================================================
    // Signals
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic go = 1'b0;
    logic reqBreak = 1'b0;
    logic signed [23:0] reqTemp = '0;
    logic [7:0] awaddr = '0;
    logic [7:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic sampleValid, sampleWireBreak, resultValid, diagAlarm, irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic signed [23:0] sampleTemp;
    logic signed [15:0] measValue;
    nrc_pkg::nrc_class_type rangeClass;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rv;
    logic [4:0] ctrl;
    logic [4:0] modes [7] = '{5'h10, 5'h12, 5'h14, 5'h11, 5'h13, 5'h15, 5'h06};
    logic [18:0] lastRes = '0;
    logic [2:0] lastCause = 3'h0;
    int n_diag = 0;
    int corner [14] = '{25000, 25010, 29500, 29510, -6000, -6010, -10500, -10510,
        13000, 13001, 15500, 15501, -6001, -10501};
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;

    // Clock
    initial
    begin
        forever #25 clk = ~clk;
    end

    nrc_front_end i_nrc_front_end (.clk(clk), .go(go), .reqTemp(reqTemp),
        .reqBreak(reqBreak), .sampleValid(sampleValid), .sampleTemp(sampleTemp),
        .sampleWireBreak(sampleWireBreak));

    nrc_classifier i_nrc_classifier (.clk(clk), .reset_n(reset_n),
        .sampleValid(sampleValid), .sampleTemp(sampleTemp),
        .sampleWireBreak(sampleWireBreak), .measValue(measValue),
        .rangeClass(rangeClass), .resultValid(resultValid), .diagAlarm(diagAlarm),
        .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));

    // ========================================================================
    // Tasks
    task give_verdict;
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        chk("bresp", {30'h0, bresp}, {30'h0, nrc_pkg::RESP_OKAY});
    endtask : wr

    task automatic rd(logic [7:0] a, logic [1:0] er, logic [31:0] ed);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
        chk("rdata", rdata, ed);
    endtask : rd

    // Expected {class, code} from enables, scale and temperature
    function automatic logic [18:0] expect_res(logic [4:0] c, logic brk, int t);
        int v;
        int lim [4];
        if (brk)
            return c[3] ? {3'h5, 16'h7FFF} : {3'h4, 16'h8000};
        lim = nrc_pkg::STD_C_LIMITS;
        v = t / 10;
        if (c[0] && c[2:1] == 2'h1)
        begin
            v = 9 * t / 5 + 3200;
            lim = nrc_pkg::CLIM_F_LIMITS;
        end
        else if (c[0])
        begin
            v = t;
            lim = nrc_pkg::CLIM_C_LIMITS;
        end
        else if (c[2:1] == 2'h1)
        begin
            v = 9 * t / 50 + 320;
            lim = nrc_pkg::STD_F_LIMITS;
        end
        else if (c[2:1] == 2'h2)
        begin
            v = t / 10 + 2732;
            lim = nrc_pkg::STD_K_LIMITS;
        end
        if (v > lim[1])
            return {3'h3, 16'h7FFF};
        if (v < lim[3])
            return {3'h4, 16'h8000};
        return {v > lim[0] ? 3'h1 : (v < lim[2] ? 3'h2 : 3'h0), v[15:0]};
    endfunction : expect_res

    task automatic smp(int t, logic brk);
        logic [18:0] e;
        logic al;
        e = expect_res(ctrl, brk, t);
        al = brk ? (ctrl[3] | ctrl[4]) : (ctrl[4] && e[18:16] inside {3'h3, 3'h4});
        @(posedge clk);
        go <= 1'b1;
        reqTemp <= t[23:0];
        reqBreak <= brk;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        chk("result", {13'h0, rangeClass, measValue}, {13'h0, e});
        chk("flags", {30'h0, resultValid, diagAlarm}, {30'h0, 1'b1, al});
        // Track what the value and diagnostics registers should hold
        lastRes = e;
        if (al)
        begin
            n_diag++;
            lastCause = e[18:16];
        end
    endtask : smp

    // ========================================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'hD7A5));
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rd(nrc_pkg::ADDR_CTRL, nrc_pkg::RESP_OKAY, 32'h0);
        chk("reset", {12'h0, irq, rangeClass, measValue}, 32'h0);
        rd(8'h14, nrc_pkg::RESP_SLVERR, 32'h0);
        for (int m = 0; m < 7; m++)
        begin
            ctrl = modes[m];
            wr(nrc_pkg::ADDR_CTRL, {27'h0, ctrl});
            foreach (corner[i])
                smp(corner[i], 1'b0);
            repeat (30) smp(int'($urandom_range(80000)) - 40000, 1'b0);
        end
        for (int w = 0; w < 4; w++)
        begin
            ctrl = 5'(w << 3);
            wr(nrc_pkg::ADDR_CTRL, {27'h0, ctrl});
            wr(nrc_pkg::ADDR_STATUS, 32'hF);
            smp(int'($urandom_range(9000)), 1'b1);
            rd(nrc_pkg::ADDR_STATUS, nrc_pkg::RESP_OKAY,
                {28'h0, 2'h2, ctrl[4] & ~ctrl[3], ctrl[3]});
        end
        chk("irq masked", {31'h0, irq}, 32'h0);
        // Clear leftover status so the unmasked event alone raises irq
        wr(nrc_pkg::ADDR_STATUS, 32'hF);
        wr(nrc_pkg::ADDR_MASK, 32'h1);
        chk("irq idle", {31'h0, irq}, 32'h0);
        smp(0, 1'b1);
        @(posedge clk);
        #1;
        chk("irq", {31'h0, irq}, 32'h1);
        wr(nrc_pkg::ADDR_STATUS, 32'h1);
        @(posedge clk);
        #1;
        chk("irq clear", {31'h0, irq}, 32'h0);
        rd(nrc_pkg::ADDR_VALUE, nrc_pkg::RESP_OKAY, {13'h0, lastRes});
        rd(nrc_pkg::ADDR_DIAG, nrc_pkg::RESP_OKAY, {13'h0, lastCause, n_diag[15:0]});
        give_verdict();
    end
endmodule : testbench
